// [rtl/sfbs_framer.sv]
// Overview of operation
// - Every outgoing frame opens with the start delimiter 0xAB.
// - Every outgoing frame closes with the end delimiter 0xCD.
// - No delimiter value appears between the two delimiters.
// - The escape marker inside frames is the byte 0xEF.
// - A body byte equal to a delimiter goes out as 0xEF, then itself plus one.
// - A body byte equal to 0xEF goes out as an extra 0xEF, then unchanged.
// - Escaping covers every body byte, type and identifier bytes included.
// - Every message kind crosses the link only inside a delimited frame.
// - The link runs at 19200 baud, 8 data bits, no parity, 1 stop bit.
// - The two-byte identifier after the type byte travels low byte first.
module sfbs_framer
    import sfbs_pkg::*;
(
    input  wire logic        sys_clk,       // 40 MHz clock
    input  wire logic        rst_n,         // Synchronous reset, active low
    input  wire logic        clk_en,        // Freezes all state when low
    input  wire sfbs_beat_t  msg_in,        // Message byte to frame
    input  wire logic        msg_in_valid,  // msg_in is offered
    output logic             msg_in_ready,  // msg_in taken this cycle
    output logic [7:0]       line_tx_data,  // Byte to the UART transmitter
    output logic             line_tx_valid, // line_tx_data is offered
    input  wire logic        line_tx_ready, // UART takes line_tx_data
    input  wire logic [7:0]  line_rx_data,  // Byte from the UART receiver
    input  wire logic        line_rx_valid, // line_rx_data strobe
    output sfbs_beat_t       msg_out,       // Decoded message byte
    output logic             msg_out_valid, // msg_out strobe
    output logic [7:0]       rx_type,       // First body byte of frame
    output logic [15:0]      rx_peer_id,    // Identifier bytes of frame
    output logic             rx_err,        // Broken frame strobe
    output logic             baud_tick      // Bit-rate tick for the UART
);

    sfbs_state_t st_ff;
    sfbs_state_t nxt_st;
    logic        slot_free;
    logic        rx_take;
    logic [7:0]  rx_byte;

    assign msg_in_ready  = clk_en && (st_ff.tx_st == TX_BODY) && slot_free;
    assign line_tx_data  = st_ff.lt_data;
    assign line_tx_valid = st_ff.lt_valid;
    assign msg_out       = st_ff.mo;
    assign msg_out_valid = st_ff.mo_valid;
    assign rx_type       = st_ff.rx_type;
    assign rx_peer_id    = st_ff.peer_id;
    assign rx_err        = st_ff.rx_err;
    assign baud_tick     = st_ff.baud_tick;

    always_comb begin
        nxt_st           = st_ff;
        slot_free        = !st_ff.lt_valid || line_tx_ready;
        rx_take          = 1'b0;
        rx_byte          = line_rx_data;
        nxt_st.mo_valid  = 1'b0;
        nxt_st.rx_err    = 1'b0;
        nxt_st.baud_tick = 1'b0;

        // Tick only; the UART owns 8N1 framing
        if (st_ff.baud_cnt == SFBS_BIT_LAST) begin
            nxt_st.baud_cnt  = '0;
            nxt_st.baud_tick = 1'b1;
        end else begin
            nxt_st.baud_cnt = st_ff.baud_cnt + SFBS_CNT_STEP;
        end

        if (slot_free) begin
            nxt_st.lt_valid = 1'b0;
        end
        case (st_ff.tx_st)
            TX_IDLE: begin
                // Delimiter goes out before the first byte is taken
                if (slot_free && msg_in_valid) begin
                    nxt_st.lt_data  = SFBS_START;
                    nxt_st.lt_valid = 1'b1;
                    nxt_st.tx_st    = TX_BODY;
                end
            end
            TX_BODY: begin
                if (slot_free && msg_in_valid) begin
                    nxt_st.lt_valid  = 1'b1;
                    nxt_st.pend_last = msg_in.last;
                    if (sfbs_is_delim(msg_in.data)) begin
                        nxt_st.lt_data = SFBS_STUFF;
                        nxt_st.pend    = 8'(msg_in.data + SFBS_BUMP);
                        nxt_st.tx_st   = TX_ESC;
                    end else if (msg_in.data == SFBS_STUFF) begin
                        nxt_st.lt_data = SFBS_STUFF;
                        nxt_st.pend    = msg_in.data;
                        nxt_st.tx_st   = TX_ESC;
                    end else begin
                        nxt_st.lt_data = msg_in.data;
                        nxt_st.tx_st   = msg_in.last ? TX_ENDS : TX_BODY;
                    end
                end
            end
            TX_ESC: begin
                if (slot_free) begin
                    nxt_st.lt_data  = st_ff.pend;
                    nxt_st.lt_valid = 1'b1;
                    nxt_st.tx_st    = st_ff.pend_last ? TX_ENDS : TX_BODY;
                end
            end
            TX_ENDS: begin
                if (slot_free) begin
                    nxt_st.lt_data  = SFBS_END;
                    nxt_st.lt_valid = 1'b1;
                    nxt_st.tx_st    = TX_IDLE;
                end
            end
            default: begin
                nxt_st.tx_st = TX_IDLE;
            end
        endcase

        if (line_rx_valid) begin
            // A start always resyncs, even mid-frame
            if (line_rx_data == SFBS_START) begin
                nxt_st.rx_err = (st_ff.rx_st != RX_HUNT);
                nxt_st.rx_st  = RX_BODY;
                nxt_st.held_v = 1'b0;
                nxt_st.idx    = SFBS_IDX_TYPE;
            end else begin
                case (st_ff.rx_st)
                    RX_HUNT: begin
                        // Bytes outside a frame are noise
                        nxt_st.rx_st = RX_HUNT;
                    end
                    RX_BODY: begin
                        if (line_rx_data == SFBS_END) begin
                            nxt_st.mo       = '{data  : st_ff.held,
                                                first : st_ff.held_first,
                                                last  : 1'b1};
                            nxt_st.mo_valid = st_ff.held_v;
                            nxt_st.held_v   = 1'b0;
                            nxt_st.rx_st    = RX_HUNT;
                        end else if (line_rx_data == SFBS_STUFF) begin
                            nxt_st.rx_st = RX_ESC;
                        end else begin
                            rx_take = 1'b1;
                        end
                    end
                    RX_ESC: begin
                        if (line_rx_data == SFBS_END) begin
                            nxt_st.rx_err = 1'b1;
                            nxt_st.held_v = 1'b0;
                            nxt_st.rx_st  = RX_HUNT;
                        end else begin
                            rx_take      = 1'b1;
                            rx_byte      = sfbs_unstuff(line_rx_data);
                            nxt_st.rx_st = RX_BODY;
                        end
                    end
                    default: begin
                        nxt_st.rx_st = RX_HUNT;
                    end
                endcase
            end
        end

        // One byte held back so the end delimiter can mark it last
        if (rx_take) begin
            nxt_st.mo         = '{data  : st_ff.held,
                                  first : st_ff.held_first,
                                  last  : 1'b0};
            nxt_st.mo_valid   = st_ff.held_v;
            nxt_st.held       = rx_byte;
            nxt_st.held_v     = 1'b1;
            nxt_st.held_first = (st_ff.idx == SFBS_IDX_TYPE);
            case (st_ff.idx)
                SFBS_IDX_TYPE:  nxt_st.rx_type       = rx_byte;
                SFBS_IDX_ID_LO: nxt_st.peer_id[7:0]  = rx_byte;
                SFBS_IDX_ID_HI: nxt_st.peer_id[15:8] = rx_byte;
                default:        nxt_st.idx           = st_ff.idx;
            endcase
            nxt_st.idx = sfbs_next_idx(st_ff.idx);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st_ff <= SFBS_STATE_RST;
        end else if (clk_en) begin
            st_ff <= nxt_st;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    logic tx_take;
    assign tx_take = msg_in_valid && msg_in_ready;

    sequence s_esc_out;
        (st_ff.tx_st == TX_ESC) && line_tx_valid
            && (line_tx_data == SFBS_STUFF);
    endsequence

    sequence s_take_delim;
        tx_take && sfbs_is_delim(msg_in.data);
    endsequence

    sequence s_take_stuff;
        tx_take && (msg_in.data == SFBS_STUFF);
    endsequence

    chk_sof_first: assert property (
        (clk_en && st_ff.tx_st == TX_IDLE && slot_free && msg_in_valid)
        |=> (line_tx_valid && line_tx_data == SFBS_START
             && st_ff.tx_st == TX_BODY))
        else $error("frame did not open with start delimiter");

    chk_eof_close: assert property (
        (clk_en && st_ff.tx_st == TX_ENDS && slot_free)
        |=> (line_tx_valid && line_tx_data == SFBS_END
             && st_ff.tx_st == TX_IDLE))
        else $error("frame did not close with end delimiter");

    chk_body_clean: assert property (
        // Start byte only stands in body state, right after idle
        (line_tx_valid && st_ff.tx_st != TX_IDLE)
        |-> (line_tx_data != SFBS_END
             && (st_ff.tx_st == TX_BODY || line_tx_data != SFBS_START)))
        else $error("delimiter value inside frame body");

    chk_esc_marker: assert property (
        (line_tx_valid && st_ff.tx_st == TX_ESC)
        |-> (line_tx_data == SFBS_STUFF))
        else $error("escape marker has wrong value");

    chk_delim_bump: assert property (
        s_take_delim |=> s_esc_out
            ##0 (st_ff.pend == 8'($past(msg_in.data) + SFBS_BUMP)))
        else $error("delimiter byte not escaped and bumped");

    chk_stuff_dup: assert property (
        s_take_stuff |=> s_esc_out ##0 (st_ff.pend == $past(msg_in.data)))
        else $error("stuff byte not doubled unchanged");

    chk_rx_unstuff: assert property (
        (clk_en && line_rx_valid && st_ff.rx_st == RX_ESC
         && line_rx_data != SFBS_START && line_rx_data != SFBS_END)
        |=> (st_ff.held_v
             && st_ff.held == sfbs_unstuff($past(line_rx_data))))
        else $error("escaped byte decoded wrongly");

    chk_id_order: assert property (
        (clk_en && rx_take && st_ff.idx == SFBS_IDX_ID_LO)
        |=> (rx_peer_id[7:0] == $past(rx_byte)))
        else $error("identifier low byte not taken first");

    chk_rx_hunt: assert property (
        (clk_en && st_ff.rx_st == RX_HUNT
         && !(line_rx_valid && line_rx_data == SFBS_START))
        |=> !msg_out_valid)
        else $error("byte delivered outside a frame");

    chk_baud_gap: assert property (
        (clk_en && baud_tick) |=> !baud_tick)
        else $error("bit-rate tick longer than one cycle");

endmodule

// [rtl/sfbs_pkg.sv]
package sfbs_pkg;

    localparam logic [7:0]  SFBS_START     = 8'hAB;
    localparam logic [7:0]  SFBS_END       = 8'hCD;
    localparam logic [7:0]  SFBS_STUFF     = 8'hEF;
    localparam logic [7:0]  SFBS_BUMP      = 8'h01;

    localparam logic [7:0]  SFBS_TYPE_DATA = 8'h65;
    localparam logic [7:0]  SFBS_TYPE_TELE = 8'h68;
    localparam logic [7:0]  SFBS_TYPE_PING = 8'h6A;
    localparam logic [7:0]  SFBS_TYPE_CMD  = 8'h6D;

    localparam int          SFBS_CLK_HZ    = 40_000_000;
    localparam int          SFBS_BAUD      = 19200;
    localparam int          SFBS_BIT_CYC   = SFBS_CLK_HZ / SFBS_BAUD;
    localparam logic [11:0] SFBS_BIT_LAST  = 12'(SFBS_BIT_CYC - 1);
    localparam logic [11:0] SFBS_CNT_STEP  = 12'h001;

    localparam logic [1:0]  SFBS_IDX_TYPE  = 2'h0;
    localparam logic [1:0]  SFBS_IDX_ID_LO = 2'h1;
    localparam logic [1:0]  SFBS_IDX_ID_HI = 2'h2;
    localparam logic [1:0]  SFBS_IDX_BODY  = 2'h3;
    localparam logic [1:0]  SFBS_IDX_STEP  = 2'h1;

    typedef enum logic [3:0] {
        TX_IDLE = 4'h1,
        TX_BODY = 4'h2,
        TX_ESC  = 4'h4,
        TX_ENDS = 4'h8
    } sfbs_tx_st_t;

    typedef enum logic [2:0] {
        RX_HUNT = 3'h1,
        RX_BODY = 3'h2,
        RX_ESC  = 3'h4
    } sfbs_rx_st_t;

    typedef struct packed {
        logic [7:0] data;
        logic       first;
        logic       last;
    } sfbs_beat_t;

    typedef struct packed {
        sfbs_tx_st_t tx_st;
        logic [7:0]  lt_data;
        logic        lt_valid;
        logic [7:0]  pend;
        logic        pend_last;
        sfbs_rx_st_t rx_st;
        logic [7:0]  held;
        logic        held_v;
        logic        held_first;
        logic [1:0]  idx;
        sfbs_beat_t  mo;
        logic        mo_valid;
        logic [7:0]  rx_type;
        logic [15:0] peer_id;
        logic        rx_err;
        logic [11:0] baud_cnt;
        logic        baud_tick;
    } sfbs_state_t;

    localparam sfbs_state_t SFBS_STATE_RST = '{
        tx_st   : TX_IDLE,
        rx_st   : RX_HUNT,
        default : '0
    };

    function automatic logic sfbs_is_delim(input logic [7:0] b);
        return (b == SFBS_START) || (b == SFBS_END);
    endfunction

    function automatic logic [7:0] sfbs_unstuff(input logic [7:0] b);
        return (b == SFBS_STUFF) ? b : 8'(b - SFBS_BUMP);
    endfunction

    function automatic logic [1:0] sfbs_next_idx(input logic [1:0] i);
        return (i == SFBS_IDX_BODY) ? i : 2'(i + SFBS_IDX_STEP);
    endfunction

endpackage

// [verification/serial_frame_byte_stuffer_bench.sv]
module serial_frame_byte_stuffer_bench;
    import sfbs_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0, rst_n = 1'b0, slow = 1'b0, msg_in_valid = 1'b0;
    logic clk_en = 1'b1;
    logic msg_in_ready, line_tx_valid, line_tx_ready, line_rx_valid;
    logic msg_out_valid, rx_err, baud_tick;
    logic [7:0] line_tx_data, line_rx_data, rx_type;
    logic [15:0] rx_peer_id;
    sfbs_beat_t msg_in = '0, msg_out;
    logic [7:0] exp_q[$];
    logic [9:0] out_q[$];
    int n_mismatch = 0, tests_run = 0, cyc = 0, last_tick = 0, per = 0;
    int n_err = 0;
    always #12.5 sys_clk = ~sys_clk;
    sfbs_framer i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
        .msg_in(msg_in), .msg_in_valid(msg_in_valid),
        .msg_in_ready(msg_in_ready), .line_tx_data(line_tx_data),
        .line_tx_valid(line_tx_valid), .line_tx_ready(line_tx_ready),
        .line_rx_data(line_rx_data), .line_rx_valid(line_rx_valid),
        .msg_out(msg_out), .msg_out_valid(msg_out_valid), .rx_type(rx_type),
        .rx_peer_id(rx_peer_id), .rx_err(rx_err), .baud_tick(baud_tick));
    sfbs_line_model i_line (.sys_clk(sys_clk), .slow(slow),
        .tx_data(line_tx_data), .tx_valid(line_tx_valid),
        .tx_ready(line_tx_ready), .rx_data(line_rx_data),
        .rx_valid(line_rx_valid));
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (msg_out_valid === 1'b1)
            out_q.push_back({msg_out.first, msg_out.last, msg_out.data});
        if (rx_err === 1'b1)
            n_err <= n_err + 1;
        if (baud_tick === 1'b1) begin
            if (last_tick != 0)
                per <= cyc - last_tick;
            last_tick <= cyc;
        end
        if (cyc == 20000) begin
            n_mismatch = n_mismatch + 1;
            end_sim();
        end
    end
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        tests_run = tests_run + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("mismatches=%0d comparisons=%0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Expected line image built from the escaping rules alone
    task automatic add_frame(input logic [7:0] m[$]);
        exp_q.push_back(8'hAB);
        foreach (m[i]) begin
            if (m[i] == 8'hAB || m[i] == 8'hCD || m[i] == 8'hEF)
                exp_q.push_back(8'hEF);
            exp_q.push_back((m[i] == 8'hEF) ? m[i] : 8'(m[i] + 8'h01));
            if (m[i] != 8'hAB && m[i] != 8'hCD)
                exp_q[$] = m[i];
        end
        exp_q.push_back(8'hCD);
    endtask
    // Valid stays up between messages so back-to-back is exercised
    task automatic put_msg(input logic [7:0] m[$]);
        int t;
        add_frame(m);
        foreach (m[i]) begin
            msg_in.data = m[i];
            msg_in.last = (i == m.size() - 1);
            msg_in_valid = 1'b1;
            t = 0;
            do begin
                @(negedge sys_clk);
                t++;
            end while (msg_in_ready !== 1'b1 && t < 200);
            if (t >= 200)
                n_mismatch = n_mismatch + 1;
            @(posedge sys_clk);
            #1;
        end
    endtask
    task automatic chk_line();
        int t;
        msg_in_valid = 1'b0;
        t = 0;
        while (i_line.got.size() < exp_q.size() && t < 400) begin
            @(posedge sys_clk);
            t++;
        end
        repeat (4) @(posedge sys_clk);
        #1;
        cmp(16'(i_line.got.size()), 16'(exp_q.size()));
        foreach (exp_q[i])
            cmp({8'h00, i_line.got[i]}, {8'h00, exp_q[i]});
        i_line.got.delete();
        exp_q.delete();
    endtask
    task automatic t_example();
        put_msg({8'h65, 8'h45, 8'h31, 8'h12, 8'h15, 8'hAB, 8'h33, 8'hEF,
                 8'h6F});
        chk_line();
    endtask
    task automatic t_header_stall();
        slow = 1'b1;
        put_msg({8'hAB, 8'hCD, 8'hEF, 8'h01});
        put_msg({8'h65, 8'h34, 8'h12});
        put_msg({8'h68, 8'h00});
        put_msg({8'h6A});
        put_msg({8'h6D, 8'hCD, 8'hAB, 8'h41});
        chk_line();
        slow = 1'b0;
    endtask
    // Offer held while frozen: nothing may leave the framer
    task automatic t_freeze();
        clk_en = 1'b0;
        msg_in = '{data: 8'h41, first: 1'b0, last: 1'b1};
        msg_in_valid = 1'b1;
        repeat (3) @(posedge sys_clk);
        #1;
        cmp({14'h0000, line_tx_valid, msg_in_ready}, 16'h0000);
        clk_en = 1'b1;
        msg_in_valid = 1'b0;
    endtask
    task automatic t_decode();
        logic [7:0] s[$] = {8'h6A, 8'hAB, 8'h6D, 8'hEF, 8'hCE, 8'hEF,
                            8'hEF, 8'h33, 8'hCD};
        foreach (s[i])
            i_line.send(s[i]);
        repeat (3) @(posedge sys_clk);
        cmp(16'(out_q.size()), 16'h0004);
        cmp({6'h00, out_q[0]}, 16'h026D);
        cmp({6'h00, out_q[1]}, 16'h00CD);
        cmp({6'h00, out_q[2]}, 16'h00EF);
        cmp({6'h00, out_q[3]}, 16'h0133);
        cmp({8'h00, rx_type}, 16'h006D);
        cmp(rx_peer_id, 16'hEFCD);
        out_q.delete();
    endtask
    task automatic t_broken();
        logic [7:0] s[$] = {8'hAB, 8'h41, 8'hAB, 8'h68, 8'hCD, 8'hAB, 8'h65,
                            8'hEF, 8'hCD};
        foreach (s[i])
            i_line.send(s[i]);
        repeat (3) @(posedge sys_clk);
        cmp(16'(n_err), 16'h0002);
        cmp(16'(out_q.size()), 16'h0001);
        cmp({6'h00, out_q[0]}, 16'h0368);
    endtask
    initial begin
        repeat (6) @(posedge sys_clk);
        #1;
        rst_n = 1'b1;
        cmp({12'h000, line_tx_valid, msg_out_valid, rx_err, msg_in_ready},
            16'h0000);
        t_example();
        t_header_stall();
        t_freeze();
        t_decode();
        t_broken();
        repeat (2 * SFBS_BIT_CYC + 10) @(posedge sys_clk);
        cmp(16'(per), 16'(SFBS_BIT_CYC));
        end_sim();
    end
endmodule

// [verification/sfbs_line_model.sv]
module sfbs_line_model
    import sfbs_pkg::*;
(
    input  wire logic       sys_clk,  // 40 MHz clock
    input  wire logic       slow,     // Stall every other cycle
    input  wire logic [7:0] tx_data,  // Byte from the framer
    input  wire logic       tx_valid, // Byte offered
    output logic            tx_ready, // Byte taken
    output logic [7:0]      rx_data,  // Byte to the framer
    output logic            rx_valid  // Byte strobe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] got[$];
    logic       tog;
    initial begin
        tog = 1'b0;
        tx_ready = 1'b1;
        rx_data = 8'h00;
        rx_valid = 1'b0;
    end
    // Line bytes kept in arrival order for the bench to judge
    always @(posedge sys_clk) begin
        if (tx_valid && tx_ready)
            got.push_back(tx_data);
        tog <= ~tog;
        tx_ready <= #1 ~slow | tog;
    end
    // Idle line shows the inverted byte, never a stale copy
    task automatic send(input logic [7:0] b);
        @(posedge sys_clk);
        #1;
        rx_data = b;
        rx_valid = 1'b1;
        @(posedge sys_clk);
        #1;
        rx_valid = 1'b0;
        rx_data = ~b;
    endtask
endmodule
